/* dma_irq_status_clear_bank.sv */
// Top: register port, channel flags and interrupt collection
//
// Design decisions made here: the address-and-strobe port and the register offsets.
module dma_irq_status_clear_bank (
  input wire logic clk, // System clock 25 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic [7:0] addr, // Register byte address
  input wire logic [31:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [31:0] rdata, // Read data, cycle after rd
  input dma_irq_pkg::chan_evt_t [1:0] chanEvt, // Channel events
  output logic [1:0] maskedTc, // Masked terminal count
  output logic [1:0] maskedErr, // Masked error
  output logic irq // Interrupt level
);
  //------------------------------------------------------------
  // Address decode
  //------------------------------------------------------------
  logic [1:0] tcEn_q, tcEn_d, errEn_q, errEn_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rawTc, rawErr, enabled, tcClr, errClr;
  logic [3:0] irqStatus, irqMask, irqEvents;
  logic selTcClr, selErrClr, selTcEn, selErrEn, selMask, rdIrq;

  assign selTcClr = wr && addr == dma_irq_pkg::OffTcClear;
  assign selErrClr = wr && addr == dma_irq_pkg::OffErrClear;
  assign selTcEn = wr && addr == dma_irq_pkg::OffTcEnable;
  assign selErrEn = wr && addr == dma_irq_pkg::OffErrEnable;
  assign selMask = wr && addr == dma_irq_pkg::OffIrqMask;
  assign rdIrq = rd && addr == dma_irq_pkg::OffIrqStatus;

  // Write-one clear pulses, zero bits do nothing
  assign tcClr = selTcClr ? wdata[1:0] : 2'h0;
  assign errClr[dma_irq_pkg::BitCh1] = selErrClr
    & wdata[dma_irq_pkg::BitCh1];
  assign errClr[dma_irq_pkg::BitCh0] = selErrClr
    & wdata[dma_irq_pkg::BitCh0];

  assign tcEn_d = selTcEn ? wdata[1:0] : tcEn_q;
  assign errEn_d = selErrEn ? wdata[1:0] : errEn_q;

  //------------------------------------------------------------
  // Channel flags
  //------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < dma_irq_pkg::NumChan; gi++) begin : gChan
      chan_flags uFlags (
        .clk(clk),
        .rst_n(rst_n),
        .evt(chanEvt[gi]),
        .tcClr(tcClr[gi]),
        .errClr(errClr[gi]),
        .rawTc(rawTc[gi]),
        .rawErr(rawErr[gi]),
        .enabled(enabled[gi])
      );
    end
  endgenerate

  // Masked views
  assign maskedTc = rawTc & tcEn_q;
  assign maskedErr = rawErr & errEn_q;

  //------------------------------------------------------------
  // Interrupt collection
  //------------------------------------------------------------
  assign irqEvents = {chanEvt[1].errEvent, chanEvt[0].errEvent,
    chanEvt[1].tcEvent, chanEvt[0].tcEvent};

  irq_collect uIrq (
    .clk(clk),
    .rst_n(rst_n),
    .events(irqEvents),
    .rdClr(rdIrq),
    .maskWr(selMask),
    .maskIn(wdata[3:0]),
    .status(irqStatus),
    .mask(irqMask),
    .irq(irq)
  );

  //------------------------------------------------------------
  // Read mux, write-only and unmapped read zero
  //------------------------------------------------------------
  always_comb begin
    rdata_d = 32'h0;
    if (rd) begin
      unique case (addr)
        dma_irq_pkg::OffMaskedTc: rdata_d[1:0] = maskedTc;
        dma_irq_pkg::OffMaskedErr: rdata_d[1:0] = maskedErr;
        dma_irq_pkg::OffRawTc: rdata_d[1:0] = rawTc;
        dma_irq_pkg::OffRawErr: rdata_d[1:0] = rawErr;
        dma_irq_pkg::OffEnabled: rdata_d[1:0] = enabled;
        dma_irq_pkg::OffTcEnable: rdata_d[1:0] = tcEn_q;
        dma_irq_pkg::OffErrEnable: rdata_d[1:0] = errEn_q;
        dma_irq_pkg::OffIrqStatus: rdata_d[3:0] = irqStatus;
        dma_irq_pkg::OffIrqMask: rdata_d[3:0] = irqMask;
        default: rdata_d = 32'h0;
      endcase
    end
  end

  // Enables and read data registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tcEn_q <= dma_irq_pkg::RstFlags;
      errEn_q <= dma_irq_pkg::RstFlags;
      rdata_q <= 32'h0;
    end else begin
      tcEn_q <= tcEn_d;
      errEn_q <= errEn_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;
endmodule // dma_irq_status_clear_bank

/* dma_irq_pkg.sv */
// Package: register map, field layout and shared types of the DMA irq bank
//------------------------------------------------------------
// What this block does
// - Write one to bit 1 clears channel 1 error
// - Write one to bit 0 clears channel 0 error
// - Raw terminal count bit 1 shows channel 1
// - Raw terminal count bit 0 shows channel 0
// - Raw error bit 1 shows channel 1
// - Raw error bit 0 shows channel 0
// - Masked error flags are raw ANDed with enable
// - Masked terminal count flags gated by enable
// - Enabled bit clears when transfer count reaches zero
//------------------------------------------------------------
package dma_irq_pkg;
  localparam int NumChan = 2;
  localparam int AddrW = 8;
  // Register byte offsets
  localparam logic [7:0] OffMaskedTc = 8'h04;
  localparam logic [7:0] OffTcClear = 8'h08;
  localparam logic [7:0] OffMaskedErr = 8'h0c;
  localparam logic [7:0] OffErrClear = 8'h10;
  localparam logic [7:0] OffRawTc = 8'h14;
  localparam logic [7:0] OffRawErr = 8'h18;
  localparam logic [7:0] OffEnabled = 8'h1c;
  localparam logic [7:0] OffTcEnable = 8'h20;
  localparam logic [7:0] OffErrEnable = 8'h24;
  localparam logic [7:0] OffIrqStatus = 8'h28;
  localparam logic [7:0] OffIrqMask = 8'h2c;
  // Field positions
  localparam int BitCh0 = 0;
  localparam int BitCh1 = 1;
  // Reset values
  localparam logic [1:0] RstFlags = 2'h0;
  localparam logic [3:0] RstIrq = 4'h0;
  // Per-channel event carrier
  typedef struct packed {
    logic tcEvent;
    logic errEvent;
    logic chanStart;
    logic countZero;
  } chan_evt_t;
endpackage

/* chan_flags.sv */
// Per-channel raw flags and enable-status flag
module chan_flags (
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input dma_irq_pkg::chan_evt_t evt, // Channel events
  input wire logic tcClr, // Clear terminal count flag
  input wire logic errClr, // Clear error flag
  output logic rawTc, // Raw terminal count flag
  output logic rawErr, // Raw error flag
  output logic enabled // Channel enabled flag
);
  logic rawTc_q, rawErr_q, enabled_q;
  logic rawTc_d, rawErr_d, enabled_d;

  // Set beats clear
  assign rawTc_d = evt.tcEvent | (rawTc_q & ~tcClr);
  assign rawErr_d = evt.errEvent | (rawErr_q & ~errClr);
  // Enabled clears once the count hits zero
  assign enabled_d = evt.chanStart | (enabled_q & ~evt.countZero);

  // Flag registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rawTc_q <= 1'b0;
      rawErr_q <= 1'b0;
      enabled_q <= 1'b0;
    end else begin
      rawTc_q <= rawTc_d;
      rawErr_q <= rawErr_d;
      enabled_q <= enabled_d;
    end
  end

  assign rawTc = rawTc_q;
  assign rawErr = rawErr_q;
  assign enabled = enabled_q;
endmodule // chan_flags

/* irq_collect.sv */
// Sticky interrupt status with read-clear, mask and level output
module irq_collect (
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [3:0] events, // Event pulses
  input wire logic rdClr, // Status read clears
  input wire logic maskWr, // Mask write
  input wire logic [3:0] maskIn, // Mask write data
  output logic [3:0] status, // Sticky status
  output logic [3:0] mask, // Mask register
  output logic irq // Level interrupt
);
  logic [3:0] status_q, status_d, mask_q, mask_d;

  // Event wins over read-clear
  assign status_d = events | (status_q & {4{~rdClr}});
  assign mask_d = maskWr ? maskIn : mask_q;

  // Status and mask registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= dma_irq_pkg::RstIrq;
      mask_q <= dma_irq_pkg::RstIrq;
    end else begin
      status_q <= status_d;
      mask_q <= mask_d;
    end
  end

  assign status = status_q;
  assign mask = mask_q;
  assign irq = |(status_q & mask_q);
endmodule // irq_collect

/* dma_irq_status_clear_bank_assertions.sv */
// Checker: port-level properties of the DMA irq status bank
module dma_irq_status_clear_bank_assertions (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic [7:0] addr, // Address
  input wire logic [31:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  input wire logic [31:0] rdata, // Read data
  input dma_irq_pkg::chan_evt_t [1:0] chanEvt, // Events
  input wire logic [1:0] maskedTc, // Masked tc
  input wire logic [1:0] maskedErr, // Masked err
  input wire logic irq // Interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Access decodes
  wire clrW = wr && addr == dma_irq_pkg::OffErrClear;
  wire rdTc = rd && addr == dma_irq_pkg::OffRawTc;
  wire rdErr = rd && addr == dma_irq_pkg::OffRawErr;
  wire err0 = chanEvt[0].errEvent;
  wire err1 = chanEvt[1].errEvent;
  //----------------------------------------------------------
  // Properties
  //----------------------------------------------------------
  property p_clr1; clrW && wdata[1] && !err1 |=> !maskedErr[1]; endproperty
  a_clr1: assert property (p_clr1) else $error("err1 not cleared");
  property p_clr0; clrW && wdata[0] && !err0 |=> !maskedErr[0]; endproperty
  a_clr0: assert property (p_clr0) else $error("err0 not cleared");
  property p_keep1;
    clrW && !wdata[1] && maskedErr[1] |=> maskedErr[1];
  endproperty
  a_keep1: assert property (p_keep1) else $error("err1 lost");
  property p_tc1; chanEvt[1].tcEvent ##1 rdTc |=> rdata[1]; endproperty
  a_tc1: assert property (p_tc1) else $error("raw tc1 low");
  property p_tc0; chanEvt[0].tcEvent ##1 rdTc |=> rdata[0]; endproperty
  a_tc0: assert property (p_tc0) else $error("raw tc0 low");
  property p_err1; err1 ##1 !clrW ##1 rdErr |=> rdata[1]; endproperty
  a_err1: assert property (p_err1) else $error("raw err1 low");
  property p_err0; err0 ##1 !clrW ##1 rdErr |=> rdata[0]; endproperty
  a_err0: assert property (p_err0) else $error("raw err0 low");
  property p_merr; maskedErr[1] && rdErr |=> rdata[1]; endproperty
  a_merr: assert property (p_merr) else $error("masked err w/o raw");
  property p_mtc; maskedTc[1] && rdTc |=> rdata[1]; endproperty
  a_mtc: assert property (p_mtc) else $error("masked tc w/o raw");
  // Main scenarios
  c_clr: cover property (clrW && maskedErr[1]);
  c_tc: cover property (rdTc && maskedTc[1]);
  c_irq: cover property (irq);
endmodule // dma_irq_status_clear_bank_assertions
bind dma_irq_status_clear_bank dma_irq_status_clear_bank_assertions chk_inst (
  .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .chanEvt(chanEvt), .maskedTc(maskedTc),
  .maskedErr(maskedErr), .irq(irq));

/* tb.sv */
// Testbench: register and event scenarios of the DMA irq bank
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  dma_irq_pkg::chan_evt_t [1:0] chanEvt = '0;
  logic [1:0] maskedTc;
  logic [1:0] maskedErr;
  logic irq;
  int miscompares = 0;
  int checksDone = 0;
  always #20 clk = ~clk;
  dma_irq_status_clear_bank dma_irq_status_clear_bank_inst (.clk(clk),
    .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .chanEvt(chanEvt), .maskedTc(maskedTc),
    .maskedErr(maskedErr), .irq(irq));
  //----------------------------------------------------------
  // Access tasks
  //----------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rdReg(input logic [7:0] a, input logic [31:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 cmp(rdata, exp);
  endtask
  // One-cycle event pulse on the channels and events selected by e
  task automatic pulse(input logic [7:0] e);
    chanEvt <= e;
    @(posedge clk);
    chanEvt <= '0;
    #1;
  endtask
  task automatic end_sim;
    if (miscompares == 0 && checksDone > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #20us;
    miscompares++;
    end_sim();
  end
  //----------------------------------------------------------
  // Main sequence
  //----------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdReg(dma_irq_pkg::OffRawTc, 32'h0);
    rdReg(dma_irq_pkg::OffRawErr, 32'h0);
    wrReg(dma_irq_pkg::OffTcEnable, 32'h2);
    wrReg(dma_irq_pkg::OffErrEnable, 32'h2);
    wrReg(dma_irq_pkg::OffIrqMask, 32'hc);
    pulse(8'hcc);
    rdReg(dma_irq_pkg::OffRawTc, 32'h3);
    rdReg(dma_irq_pkg::OffRawErr, 32'h3);
    cmp({30'h0, maskedTc}, 32'h2);
    cmp({30'h0, maskedErr}, 32'h2);
    cmp({31'h0, irq}, 32'h1);
    wrReg(dma_irq_pkg::OffIrqMask, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    wrReg(dma_irq_pkg::OffIrqMask, 32'hc);
    rdReg(dma_irq_pkg::OffIrqStatus, 32'hf);
    cmp({31'h0, irq}, 32'h0);
    wrReg(dma_irq_pkg::OffErrClear, 32'h0);
    rdReg(dma_irq_pkg::OffRawErr, 32'h3);
    wrReg(dma_irq_pkg::OffErrClear, 32'h2);
    rdReg(dma_irq_pkg::OffRawErr, 32'h1);
    cmp({30'h0, maskedErr}, 32'h0);
    wrReg(dma_irq_pkg::OffErrClear, 32'h1);
    rdReg(dma_irq_pkg::OffRawErr, 32'h0);
    rdReg(dma_irq_pkg::OffErrClear, 32'h0);
    wrReg(8'hfc, 32'hffffffff);
    rdReg(8'hfc, 32'h0);
    pulse(8'h02);
    rdReg(dma_irq_pkg::OffEnabled, 32'h1);
    pulse(8'h01);
    rdReg(dma_irq_pkg::OffEnabled, 32'h0);
    end_sim();
  end
endmodule // tb
